// ### design/fgmc_defs.svh
// Constants for the multi-function high-voltage pin mode control block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef FGMC_DEFS_SVH
`define FGMC_DEFS_SVH

// Register indices on the plain register port (byte address = index).
`define FGMC_ADDR_PIN_CFG    8'h00
`define FGMC_ADDR_CTRL       8'h01
`define FGMC_ADDR_STATUS     8'h02
`define FGMC_ADDR_TIMER_PWM  8'h03
`define FGMC_ADDR_PULL       8'h04

// Pin function codes.
`define FGMC_FN_FAIL_MAX     3'h2
`define FGMC_FN_CYCLIC       3'h3
`define FGMC_FN_OFF          3'h4
`define FGMC_FN_WAKE         3'h5
`define FGMC_FN_LOW_SIDE     3'h6
`define FGMC_FN_HIGH_SIDE    3'h7

// Control register bit positions.
`define FGMC_CTRL_TEST_BIT   0
`define FGMC_CTRL_SENSE_BIT  1
`define FGMC_CTRL_LOCK_BIT   2
`define FGMC_CTRL_SOFT_BIT   3

// Status register bit positions.
`define FGMC_ST_FAILURE_BIT  0
`define FGMC_ST_CMDERR_BIT   1
`define FGMC_ST_WAKE_EV_BIT  2
`define FGMC_ST_LEVEL_BIT    3
`define FGMC_ST_OC_BIT       4

// Reset values.
`define FGMC_RST_FN          3'h0
`define FGMC_RST_TIMER_PWM   8'h00
`define FGMC_RST_PULL        2'h0

// Wake filter time in nanoseconds (minimum 13 us, typical 16, maximum 20).
`define FGMC_FILT_MIN_NS     13000
`define FGMC_FILT_MAX_NS     20000
`define FGMC_CLK_NS          8
// Least time rounds up to whole cycles.
`define FGMC_FILT_CYC        ((`FGMC_FILT_MIN_NS + `FGMC_CLK_NS - 1) / `FGMC_CLK_NS)

`endif

// ### design/fgmc_pin_ctrl.sv
// Mode-dependent control of the multi-function high-voltage pin.
// Assumes the system mode arrives one-hot on the block clock and the pin input is asynchronous.

`include "fgmc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module fgmc_pin_ctrl
    import fgmc_pkg::*;
#(
    parameter int FILT_CYC = `FGMC_FILT_CYC  // Wake filter length in clock cycles.
) (
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Register port.
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output var  logic [7:0] rdata,
    // System mode and events.
    input  wire logic [4:0] sys_mode,
    input  wire logic       fail_event,
    input  wire logic       battery_undervoltage,
    input  wire logic       overcurrent,
    input  wire logic       other_wake_sources,
    input  wire logic       sleep_request,
    input  wire logic       pwm_level,
    input  wire logic       cyclic_on,
    output var  logic       restart_request,
    // Pin side.
    input  wire logic       multi_function_hv_pin_in,
    output var  logic       fail_indicator_output,
    output var  logic       low_side_switch,
    output var  logic       high_side_switch,
    output var  logic       wake_pull_up,
    output var  logic       wake_pull_down,
    output var  logic       hv_sense_route,
    output var  logic       hv_wake_input,
    output var  logic [7:0] timer_pwm_setting
);

    // The filter counter is 16 bits wide, so longer filters cannot be served.
    if (FILT_CYC < 1 || FILT_CYC > 65535) begin : g_bad_filt
        $error("Wake filter length out of range.");
    end

    // Battery undervoltage is deliberately not read anywhere in the pin logic.
    logic unused_uv;                                    // Keeps the input visibly unused.
    assign unused_uv = battery_undervoltage;

    // Stored registers.
    logic [2:0]  pin_fn_r;            // Pin function field.
    logic        test_act_r;          // Fail output test activate.
    logic        sense_en_r;          // High-voltage sense enable.
    logic        lock_r;              // Configuration lock.
    logic [1:0]  pull_cfg_r;          // Wake pull configuration.
    logic [7:0]  timer_pwm_r;         // Timer and PWM setting.
    logic        failure_r;           // Sticky failure flag.
    logic        cmd_err_r;           // Sticky command error flag.
    logic        wake_ev_r;           // Sticky wake event status.
    logic        oc_r;                // Sticky overcurrent status.
    logic        level_r;             // Filtered wake level.
    fgmc_mode_e  mode_q;              // Previous mode for entry detection.

    // Decoded helpers.
    fgmc_mode_e  mode;
    logic        is_fail_fn, is_wake_fn, is_switch_fn, normal, entry_rs;
    logic        wr_cfg, wr_ctrl, wr_st, wr_tp, wr_pull, soft_rst;
    assign mode         = fgmc_mode_e'(sys_mode);
    assign normal       = (mode == FGMC_NORMAL);
    assign is_fail_fn   = (pin_fn_r <= `FGMC_FN_FAIL_MAX);
    assign is_wake_fn   = (pin_fn_r == `FGMC_FN_WAKE);
    assign is_switch_fn = (pin_fn_r == `FGMC_FN_LOW_SIDE)
                        || (pin_fn_r == `FGMC_FN_HIGH_SIDE)
                        || (pin_fn_r == `FGMC_FN_CYCLIC);
    // Entry to Restart or Fail-Safe from Normal, Stop or Sleep.
    assign entry_rs = ((mode == FGMC_RESTART) || (mode == FGMC_FAIL_SAFE))
                    && (mode_q != FGMC_RESTART) && (mode_q != FGMC_FAIL_SAFE);
    assign wr_cfg   = wr_en && (addr == `FGMC_ADDR_PIN_CFG);
    assign wr_ctrl  = wr_en && (addr == `FGMC_ADDR_CTRL);
    assign wr_st    = wr_en && (addr == `FGMC_ADDR_STATUS);
    assign wr_tp    = wr_en && (addr == `FGMC_ADDR_TIMER_PWM);
    assign wr_pull  = wr_en && (addr == `FGMC_ADDR_PULL);
    // Soft reset only honoured in Normal or Stop mode.
    assign soft_rst = wr_ctrl && wdata[`FGMC_CTRL_SOFT_BIT]
                    && (normal || (mode == FGMC_STOP));

    // Pin-function write is legal only in Normal, unlocked, sensing off.
    logic cfg_ok, cfg_bad;
    assign cfg_ok  = wr_cfg && normal && !lock_r && !sense_en_r;
    assign cfg_bad = wr_cfg && normal && !lock_r && sense_en_r;
    // Sensing enable request while fail output configured is refused.
    logic sense_set, sense_bad, test_bad;
    assign sense_set = wr_ctrl && wdata[`FGMC_CTRL_SENSE_BIT] && !sense_en_r;
    assign sense_bad = sense_set && is_fail_fn;
    assign test_bad  = wr_ctrl && wdata[`FGMC_CTRL_TEST_BIT] && sense_en_r;
    // Sleep with pin wake as sole source while sensing is an error.
    logic sleep_bad;
    assign sleep_bad = sleep_request && sense_en_r && is_wake_fn
                     && !other_wake_sources;

    // Previous mode register.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= FGMC_NORMAL;
        end else begin
            mode_q <= mode;
        end
    end

    // Pin function field: a switch function is rewritten Off on overcurrent or Restart/Fail-Safe entry.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_fn_r <= `FGMC_RST_FN;
        end else if (is_switch_fn && (overcurrent || entry_rs)) begin
            pin_fn_r <= `FGMC_FN_OFF;
        end else if (soft_rst && !lock_r) begin
            pin_fn_r <= `FGMC_RST_FN;
        end else if (cfg_ok) begin
            pin_fn_r <= wdata[2:0];
        end
    end

    // Control bits: lock, sensing enable and test activation.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            test_act_r <= 1'b0;
            sense_en_r <= 1'b0;
            lock_r     <= 1'b0;
        end else if (entry_rs && (mode == FGMC_RESTART)) begin
            // Test activation is dropped on Restart entry.
            test_act_r <= 1'b0;
        end else if (wr_ctrl) begin
            // Test bit may be written in any configuration, but is ignored while sensing.
            test_act_r <= wdata[`FGMC_CTRL_TEST_BIT] && !sense_en_r;
            sense_en_r <= wdata[`FGMC_CTRL_SENSE_BIT] && !sense_bad;
            lock_r     <= wdata[`FGMC_CTRL_LOCK_BIT];
        end
    end

    // Timer/PWM and pull configuration; pull writes always stored.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_pwm_r <= `FGMC_RST_TIMER_PWM;
            pull_cfg_r  <= `FGMC_RST_PULL;
        end else if (soft_rst) begin
            timer_pwm_r <= `FGMC_RST_TIMER_PWM;
            pull_cfg_r  <= `FGMC_RST_PULL;
        end else begin
            if (wr_tp) begin
                timer_pwm_r <= wdata;
            end
            if (wr_pull) begin
                pull_cfg_r <= wdata[1:0];
            end
        end
    end

    // Sticky status flags; a set in the clearing cycle wins.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            failure_r <= 1'b0;
            cmd_err_r <= 1'b0;
            oc_r      <= 1'b0;
        end else begin
            // Failure is flagged whatever the pin function, and software clears it.
            failure_r <= fail_event
                       || (failure_r && !(wr_st && wdata[`FGMC_ST_FAILURE_BIT]));
            cmd_err_r <= cfg_bad || sense_bad || test_bad || sleep_bad
                       || (cmd_err_r && !(wr_st && wdata[`FGMC_ST_CMDERR_BIT]));
            oc_r      <= (overcurrent && is_switch_fn)
                       || (oc_r && !(wr_st && wdata[`FGMC_ST_OC_BIT]));
        end
    end

    // Three-stage synchroniser for the pin input.
    logic [2:0] pin_sync_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync_r <= 3'h0;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], multi_function_hv_pin_in};
        end
    end

    // Wake filter: a level different from the accepted one must hold FILT_CYC cycles.
    logic        pin_stable, wake_gate;
    logic [15:0] filt_cnt_r;
    assign pin_stable = (pin_sync_r[2] == pin_sync_r[1]);
    assign wake_gate  = is_wake_fn && !sense_en_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            filt_cnt_r <= 16'h0000;
            level_r    <= 1'b0;
        end else if (!wake_gate || !pin_stable || (pin_sync_r[2] == level_r)) begin
            filt_cnt_r <= 16'h0000;
        end else if (filt_cnt_r == 16'(FILT_CYC - 1)) begin
            // Level keeps updating in every mode, Restart and Fail-Safe included.
            filt_cnt_r <= 16'h0000;
            level_r    <= pin_sync_r[2];
        end else begin
            filt_cnt_r <= filt_cnt_r + 16'h0001;
        end
    end

    // Wake event capture; cleared on Fail-Safe entry, set wins over software clear.
    logic level_change;
    assign level_change = wake_gate && pin_stable && (pin_sync_r[2] != level_r)
                        && (filt_cnt_r == 16'(FILT_CYC - 1));
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wake_ev_r <= 1'b0;
        end else if (level_change) begin
            wake_ev_r <= 1'b1;
        end else if ((entry_rs && (mode == FGMC_FAIL_SAFE))
                     || (wr_st && wdata[`FGMC_ST_WAKE_EV_BIT])) begin
            wake_ev_r <= 1'b0;
        end
    end

    // Pin drivers and wake outputs; Stop/Sleep keep the Normal settings.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fail_indicator_output <= 1'b0;
            low_side_switch       <= 1'b0;
            high_side_switch      <= 1'b0;
            wake_pull_up          <= 1'b0;
            wake_pull_down        <= 1'b0;
            hv_sense_route        <= 1'b0;
            hv_wake_input         <= 1'b0;
            restart_request       <= 1'b0;
        end else begin
            // Failure holds the output through every mode; test is cleared on Restart entry but can be set again in Restart.
            fail_indicator_output <= is_fail_fn && !sense_en_r
                                   && (failure_r || test_act_r);
            // Restart/Fail-Safe force switches off; Stop/Sleep hold configuration.
            low_side_switch  <= !entry_rs && (pin_fn_r == `FGMC_FN_LOW_SIDE)
                              && !sense_en_r && pwm_level;
            high_side_switch <= !entry_rs && !sense_en_r
                              && (((pin_fn_r == `FGMC_FN_HIGH_SIDE) && pwm_level)
                               || ((pin_fn_r == `FGMC_FN_CYCLIC) && cyclic_on));
            wake_pull_up     <= wake_gate && pull_cfg_r[0];
            wake_pull_down   <= wake_gate && pull_cfg_r[1];
            hv_sense_route   <= sense_en_r;
            hv_wake_input    <= level_change;
            restart_request  <= sleep_bad;
        end
    end

    // Read data, valid the cycle after the read strobe only.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (!rd_en) begin
            rdata <= 8'h00;
        end else begin
            case (addr)
                `FGMC_ADDR_PIN_CFG:   rdata <= {5'h00, pin_fn_r};
                `FGMC_ADDR_CTRL:      rdata <= {5'h00, lock_r, sense_en_r, test_act_r};
                // Level is hidden outside Normal mode.
                `FGMC_ADDR_STATUS:    rdata <= {3'h0, oc_r, level_r && normal, wake_ev_r,
                                                cmd_err_r, failure_r};
                `FGMC_ADDR_TIMER_PWM: rdata <= timer_pwm_r;
                `FGMC_ADDR_PULL:      rdata <= {6'h00, pull_cfg_r};
                default:              rdata <= 8'h00;
            endcase
        end
    end

    // Re-enable spacing after a short is left to software.
    assign timer_pwm_setting = timer_pwm_r;

endmodule // fgmc_pin_ctrl

`default_nettype wire

// ### design/fgmc_pkg.sv
// Types for the multi-function high-voltage pin mode control block.
// Assumes the constants header is compiled alongside.
package fgmc_pkg;

    // Operating modes of the device, one-hot.
    typedef enum logic [4:0] {
        FGMC_NORMAL    = 5'h01,
        FGMC_STOP      = 5'h02,
        FGMC_SLEEP     = 5'h04,
        FGMC_RESTART   = 5'h08,
        FGMC_FAIL_SAFE = 5'h10
    } fgmc_mode_e;

endpackage

// ### sim/fail_gpio_mode_control_tb_top.sv
// Register-driven test of the pin mode control with an outside pin model.
// Assumes a 125 MHz clock and a shortened wake filter.
`include "fgmc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module fail_gpio_mode_control_tb_top;
    import fgmc_pkg::*;
    localparam int FILT = 4;  // Short filter keeps the run brief.
    logic       clock, rst_n, wr_en, rd_en, fail_event, battery_undervoltage;
    logic       overcurrent, other_wake_sources, sleep_request, pwm_level;
    logic       cyclic_on, restart_request, pin, src, fail_o, ls, hs, pu, pd;
    logic       sense, wake, seen;
    logic [7:0] addr, wdata, rdata, timer;
    logic [4:0] sys_mode;
    int         num_errors, total_checks, n;

    fgmc_pin_ctrl #(.FILT_CYC(FILT)) fgmc_pin_ctrl_i (.clock(clock), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .sys_mode(sys_mode), .fail_event(fail_event),
        .battery_undervoltage(battery_undervoltage), .overcurrent(overcurrent),
        .other_wake_sources(other_wake_sources), .sleep_request(sleep_request),
        .pwm_level(pwm_level), .cyclic_on(cyclic_on), .restart_request(restart_request),
        .multi_function_hv_pin_in(pin), .fail_indicator_output(fail_o),
        .low_side_switch(ls), .high_side_switch(hs), .wake_pull_up(pu),
        .wake_pull_down(pd), .hv_sense_route(sense), .hv_wake_input(wake),
        .timer_pwm_setting(timer));
    fgmc_pin_partner fgmc_pin_partner_i (.src_level(src), .low_side_switch(ls),
        .high_side_switch(hs), .fail_indicator_output(fail_o), .pin_level(pin));

    // Free-running 8 ns clock.
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Compare one value and count the outcome.
    task automatic chk(input logic [7:0] seen_v, input logic [7:0] exp_v);
        total_checks++;
        if (seen_v !== exp_v) begin
            num_errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen_v, exp_v);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 chk(rdata & m, e);
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask
    task automatic mode(input fgmc_mode_e m);
        @(posedge clock);
        sys_mode <= m;
        step(3);
    endtask
    // Bounded wait for an accepted wake change; 40 means none came.
    task automatic wake_wait(output int c);
        c = 0;
        while (wake !== 1'b1 && c < 40) begin
            @(posedge clock);
            #1 c++;
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        {wr_en, rd_en, fail_event, battery_undervoltage, overcurrent} = 5'h00;
        {other_wake_sources, sleep_request, pwm_level, cyclic_on, src} = 5'h00;
        {addr, wdata, num_errors, total_checks} = '0;
        sys_mode = FGMC_NORMAL;
        rst_n = 1'b0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        rd(`FGMC_ADDR_PIN_CFG, 8'hFF, 8'h00);
        rd(8'h07, 8'hFF, 8'h00);
        for (int c = 3; c < 8; c++) begin
            wr(`FGMC_ADDR_PIN_CFG, 8'(c));
            rd(`FGMC_ADDR_PIN_CFG, 8'h07, 8'(c));
        end
        mode(FGMC_STOP);
        wr(`FGMC_ADDR_PIN_CFG, 8'h04);
        rd(`FGMC_ADDR_PIN_CFG, 8'h07, 8'h07);
        mode(FGMC_NORMAL);
        pwm_level <= 1'b1;
        step(3);
        chk(hs, 1);
        battery_undervoltage <= 1'b1;
        step(3);
        chk(hs, 1);
        mode(FGMC_STOP);
        chk(hs, 1);
        mode(FGMC_NORMAL);
        overcurrent <= 1'b1;
        step(1);
        overcurrent <= 1'b0;
        step(3);
        chk(hs, 0);
        rd(`FGMC_ADDR_PIN_CFG, 8'h07, 8'h04);
        step(3125);
        wr(`FGMC_ADDR_PIN_CFG, 8'h06);
        step(3);
        chk(ls, 1);
        mode(FGMC_RESTART);
        chk(ls, 0);
        mode(FGMC_NORMAL);
        chk(ls, 0);
        rd(`FGMC_ADDR_PIN_CFG, 8'h07, 8'h04);
        wr(`FGMC_ADDR_PIN_CFG, 8'h03);
        cyclic_on <= 1'b1;
        step(3);
        chk(hs, 1);
        wr(`FGMC_ADDR_PIN_CFG, 8'h04);
        wr(`FGMC_ADDR_CTRL, 8'h01);
        fail_event <= 1'b1;
        step(1);
        fail_event <= 1'b0;
        step(3);
        chk(fail_o, 0);
        rd(`FGMC_ADDR_STATUS, 8'h01, 8'h01);
        wr(`FGMC_ADDR_STATUS, 8'h01);
        rd(`FGMC_ADDR_STATUS, 8'h01, 8'h00);
        wr(`FGMC_ADDR_CTRL, 8'h00);
        wr(`FGMC_ADDR_PIN_CFG, 8'h00);
        fail_event <= 1'b1;
        step(1);
        fail_event <= 1'b0;
        mode(FGMC_RESTART);
        chk(fail_o, 1);
        mode(FGMC_NORMAL);
        chk(fail_o, 1);
        rd(`FGMC_ADDR_PIN_CFG, 8'h07, 8'h00);
        wr(`FGMC_ADDR_STATUS, 8'h01);
        wr(`FGMC_ADDR_TIMER_PWM, 8'h5A);
        wr(`FGMC_ADDR_PIN_CFG, 8'h05);
        wr(`FGMC_ADDR_CTRL, 8'h04);
        wr(`FGMC_ADDR_CTRL, 8'h0C);
        rd(`FGMC_ADDR_PIN_CFG, 8'h07, 8'h05);
        rd(`FGMC_ADDR_TIMER_PWM, 8'hFF, 8'h00);
        chk(timer, 8'h00);
        wr(`FGMC_ADDR_CTRL, 8'h00);
        src <= 1'b1;
        wake_wait(n);
        chk(8'(n >= FILT && n <= FILT + 6), 1);
        mode(FGMC_RESTART);
        src <= 1'b0;
        wake_wait(n);
        chk(8'(n < 40), 1);
        src <= 1'b1;
        wake_wait(n);
        rd(`FGMC_ADDR_STATUS, 8'h08, 8'h00);
        mode(FGMC_NORMAL);
        rd(`FGMC_ADDR_STATUS, 8'h08, 8'h08);
        wr(`FGMC_ADDR_PIN_CFG, 8'h00);
        wr(`FGMC_ADDR_CTRL, 8'h02);
        rd(`FGMC_ADDR_CTRL, 8'h02, 8'h00);
        rd(`FGMC_ADDR_STATUS, 8'h02, 8'h02);
        wr(`FGMC_ADDR_STATUS, 8'h02);
        wr(`FGMC_ADDR_PIN_CFG, 8'h05);
        wr(`FGMC_ADDR_PULL, 8'h03);
        step(2);
        chk({sense, pu, pd}, 8'h03);
        wr(`FGMC_ADDR_CTRL, 8'h02);
        step(3);
        chk({sense, pu, pd}, 8'h04);
        rd(`FGMC_ADDR_PULL, 8'h03, 8'h03);
        wr(`FGMC_ADDR_PIN_CFG, 8'h04);
        rd(`FGMC_ADDR_PIN_CFG, 8'h07, 8'h05);
        rd(`FGMC_ADDR_STATUS, 8'h02, 8'h02);
        wr(`FGMC_ADDR_STATUS, 8'h02);
        wr(`FGMC_ADDR_CTRL, 8'h03);
        rd(`FGMC_ADDR_STATUS, 8'h02, 8'h02);
        chk(fail_o, 0);
        src <= 1'b0;
        wake_wait(n);
        chk(8'(n), 8'd40);
        @(posedge clock);
        sleep_request <= 1'b1;
        @(posedge clock);
        sleep_request <= 1'b0;
        seen = 1'b0;
        for (int i = 0; i < 4; i++) begin
            #1 if (restart_request === 1'b1) seen = 1'b1;
            @(posedge clock);
        end
        chk(seen, 1);
        complete_run();
    end
endmodule // fail_gpio_mode_control_tb_top

`default_nettype wire

// ### sim/fgmc_pin_ctrl_assertions.sv
// Port-level checks for the multi-function pin mode control.
// Assumes it is bound to fgmc_pin_ctrl and shares its single clock.
`include "fgmc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module fgmc_pin_ctrl_assertions
    import fgmc_pkg::*;
#(
    parameter int FILT_CYC = 4  // Wake filter length in clock cycles.
) (
    // Clock and reset.
    input wire logic       clock,
    input wire logic       rst_n,
    // Register port.
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rdata,
    // Mode and events.
    input wire logic [4:0] sys_mode,
    input wire logic       fail_event,
    input wire logic       battery_undervoltage,
    input wire logic       overcurrent,
    input wire logic       other_wake_sources,
    input wire logic       sleep_request,
    input wire logic       pwm_level,
    input wire logic       cyclic_on,
    input wire logic       restart_request,
    // Pin side.
    input wire logic       multi_function_hv_pin_in,
    input wire logic       fail_indicator_output,
    input wire logic       low_side_switch,
    input wire logic       high_side_switch,
    input wire logic       wake_pull_up,
    input wire logic       wake_pull_down,
    input wire logic       hv_sense_route,
    input wire logic       hv_wake_input,
    input wire logic [7:0] timer_pwm_setting
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Cycles since the last accepted wake change, saturating at the filter length.
    int unsigned gap_r;

    // The filter forbids two accepted changes closer than its length.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gap_r <= FILT_CYC;
        end else if (hv_wake_input) begin
            gap_r <= 0;
        end else if (gap_r < FILT_CYC) begin
            gap_r <= gap_r + 1;
        end
    end

    a_sense_blocks_drive: assert property (
        hv_sense_route && $past(hv_sense_route) |->
        !fail_indicator_output && !low_side_switch && !high_side_switch)
        else $error("pin driven while sensing");
    a_sense_no_pulls: assert property (
        hv_sense_route && $past(hv_sense_route) |-> !wake_pull_up && !wake_pull_down)
        else $error("pull source on while sensing");
    a_sense_no_wake: assert property (
        hv_sense_route && $past(hv_sense_route) |-> !hv_wake_input)
        else $error("wake accepted while sensing");
    a_dark_modes_off: assert property (
        $past(sys_mode) inside {FGMC_RESTART, FGMC_FAIL_SAFE} &&
        $past(sys_mode, 2) inside {FGMC_RESTART, FGMC_FAIL_SAFE} |->
        !low_side_switch && !high_side_switch)
        else $error("switch on in restart or fail-safe");
    a_rdata_idle_zero: assert property (
        !$past(rd_en) |-> rdata == 8'h00)
        else $error("read data without read");
    a_level_hidden: assert property (
        $past(rd_en && addr == `FGMC_ADDR_STATUS && sys_mode != FGMC_NORMAL) |->
        rdata[`FGMC_ST_LEVEL_BIT] == 1'b0)
        else $error("wake level readable outside normal");
    a_restart_cause: assert property (
        restart_request |->
        $past(sleep_request) && !$past(other_wake_sources) && $past(hv_sense_route))
        else $error("restart request without refused sleep");
    a_wake_spacing: assert property (
        hv_wake_input |-> gap_r >= FILT_CYC - 1)
        else $error("wake changes closer than filter");

    c_wake_seen: cover property (hv_wake_input);
    c_restart_seen: cover property (restart_request);
    c_fail_seen: cover property (fail_indicator_output);
endmodule // fgmc_pin_ctrl_assertions

bind fgmc_pin_ctrl fgmc_pin_ctrl_assertions #(.FILT_CYC(FILT_CYC)) fgmc_pin_ctrl_assertions_i (.*);

`default_nettype wire

// ### sim/fgmc_pin_partner.sv
// Outside world on the pin: a load plus a wake signal source.
// Assumes switch and fail outputs are active-high drive requests.
`timescale 1ns/1ps
`default_nettype none

module fgmc_pin_partner (
    // Level the outside source would put on an idle pin.
    input wire logic src_level,
    // Drive from the block.
    input wire logic low_side_switch,
    input wire logic high_side_switch,
    input wire logic fail_indicator_output,
    // Resulting pin level.
    output var logic pin_level
);
    // A driven switch or the fail output overrides the weak outside source.
    always_comb begin
        if (high_side_switch) begin
            pin_level = 1'b1;
        end else if (low_side_switch || fail_indicator_output) begin
            pin_level = 1'b0;
        end else begin
            pin_level = src_level;
        end
    end
endmodule // fgmc_pin_partner

`default_nettype wire
